// file: design/frt_pkg.sv
/*
 Package for the free-running timer with compare and capture.
 Assumes a byte-wide CPU register port with one-cycle strobes.
*/
package frt_pkg;
    // ***********************************
    // Register map
    // ***********************************
    localparam logic [15:0] ADDR_PORT5_DIR = 16'hff25;
    localparam logic [15:0] ADDR_TMODE = 16'hff5b;
    localparam logic [15:0] ADDR_CMP_LO = 16'hff16;
    localparam logic [15:0] ADDR_CMP_HI = 16'hff17;
    localparam logic [15:0] ADDR_CNT_LO = 16'hff18;
    localparam logic [15:0] ADDR_CNT_HI = 16'hff19;
    localparam logic [15:0] ADDR_CAP_LO = 16'hff1a;
    localparam logic [15:0] ADDR_CAP_HI = 16'hff1b;
    // ***********************************
    // Reset values and fields
    // ***********************************
    localparam logic [7:0] RST_PORT5_DIR = 8'hff;
    localparam logic [7:0] RST_TMODE = 8'h00;
    localparam logic [15:0] RST_CMP = 16'hffff;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam int BIT_OUT_DATA = 7;
    localparam int BIT_OVF = 6;
    localparam int BIT_EDGE_HI = 5;
    localparam int BIT_EDGE_LO = 4;
    localparam int BIT_INV = 3;
    localparam int BIT_CLK_HI = 2;
    localparam int BIT_CLK_LO = 1;
    localparam int BIT_OE = 0;
    localparam int BIT_PIN_DIR = 1;
    // ***********************************
    // Count clock dividers (system clock stands in for the oscillator)
    // ***********************************
    localparam int DIV_FAST = 4;
    localparam int DIV_SLOW = 64;
    localparam int CAPTURE_CLOCKS = 2;
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    typedef enum logic [1:0] {FRT_BUF_TRACK, FRT_BUF_HELD} frt_buf_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } frt_bus_t;
endpackage

// file: design/frt_prescaler.sv
/*
 Count clock prescaler: one-cycle tick every 4 or 64 system clocks.
 Assumes the select code is only 00 or 01.
*/
`timescale 1ns/100ps
module frt_prescaler
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [1:0] i_sel,
    output logic o_tick,
    output logic o_half
);
    logic [5:0] div_r;
    logic [5:0] div_nxt;
    logic [5:0] last;
    always_comb
    begin
        last = (i_sel == 2'h0) ? 6'(frt_pkg::DIV_FAST - 1) : 6'(frt_pkg::DIV_SLOW - 1);
        div_nxt = (div_r >= last) ? 6'h00 : div_r + 6'h01;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            div_r <= 6'h00;
        else
            div_r <= div_nxt;
    end
    assign o_tick = (div_r >= last);
    // True while the next cycle still lies in the first half of the fast period; never true at the slow rate, where the 6-bit sum last + 1 wraps to 0
    assign o_half = ((div_r + 6'h01) < ((last + 6'h01) >> 1));
endmodule

// file: design/frt_timer.sv
/*
 Free-running 16-bit timer with compare match, toggle output,
 edge capture and a counter read buffer.
 Assumes byte strobes from the CPU are synchronous and last one cycle;
 the low read strobe freezes the buffer and the high read releases it.
*/
`timescale 1ns/100ps
module frt_timer
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire frt_pkg::frt_bus_t i_bus,
    input wire logic i_capture_trigger_pin,
    input wire logic i_output_port_pin,
    output logic [7:0] o_rdata,
    output logic o_match_interrupt_request,
    output logic o_timer_output_pin,
    output logic o_timer_output_pin_oen
);
    // ***********************************
    // State
    // ***********************************
    logic [15:0] count_r, count_nxt;
    logic [15:0] cmp_r, cmp_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic [15:0] rbuf_r, rbuf_nxt;
    logic [7:0] tmode_r, tmode_nxt;
    logic [7:0] pdir_r, pdir_nxt;
    logic [7:0] rdata_nxt;
    frt_pkg::frt_buf_t buf_r, buf_nxt;
    logic trig_r, trig_nxt;
    logic cap_pend_r, cap_pend_nxt;
    logic irq_r, irq_nxt;
    logic pin_r, pin_nxt;
    logic oen_r, oen_nxt;
    logic tick, half, match, edge_hit, wr_tmode;

    frt_prescaler u_presc
    (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_sel(tmode_r[frt_pkg::BIT_CLK_HI:frt_pkg::BIT_CLK_LO]),
        .o_tick(tick),
        .o_half(half)
    );

    // ***********************************
    // Next-state logic
    // ***********************************
    always_comb
    begin
        wr_tmode = i_bus.wr && (i_bus.addr == frt_pkg::ADDR_TMODE);
        match = tick && (count_r == cmp_r);
        count_nxt = tick ? count_r + 16'h0001 : count_r;
        cmp_nxt = cmp_r;
        if (i_bus.wr && (i_bus.addr == frt_pkg::ADDR_CMP_LO))
            cmp_nxt[7:0] = i_bus.wdata;
        else if (i_bus.wr && (i_bus.addr == frt_pkg::ADDR_CMP_HI))
            cmp_nxt[15:8] = i_bus.wdata;
        pdir_nxt = pdir_r;
        if (i_bus.wr && (i_bus.addr == frt_pkg::ADDR_PORT5_DIR))
            pdir_nxt = i_bus.wdata | 8'hf0;
        tmode_nxt = tmode_r;
        if (wr_tmode)
        begin
            tmode_nxt[6:0] = i_bus.wdata[6:0];
            // Software may only clear the flag
            tmode_nxt[frt_pkg::BIT_OVF] = tmode_r[frt_pkg::BIT_OVF]
                                          & i_bus.wdata[frt_pkg::BIT_OVF];
            if (i_bus.wdata[frt_pkg::BIT_OE] && !tmode_r[frt_pkg::BIT_OE])
                tmode_nxt[frt_pkg::BIT_OUT_DATA] = 1'b0;
        end
        // Overflow set wins over a software clear in the same cycle
        if (tick && count_r == frt_pkg::CNT_MAX)
            tmode_nxt[frt_pkg::BIT_OVF] = 1'b1;
        if (match && tmode_r[frt_pkg::BIT_INV])
            tmode_nxt[frt_pkg::BIT_OUT_DATA] = ~tmode_nxt[frt_pkg::BIT_OUT_DATA];
        // Request high from match through the first half of the fast tick period; at the slow rate half never rises, so it lasts one cycle
        irq_nxt = match || (irq_r && half && !tick) ? 1'b1 : 1'b0;
    end

    // ***********************************
    // Trigger edge and capture
    // ***********************************
    always_comb
    begin
        trig_nxt = i_capture_trigger_pin;
        case (tmode_r[frt_pkg::BIT_EDGE_HI:frt_pkg::BIT_EDGE_LO])
            frt_pkg::EDGE_RISE: edge_hit = i_capture_trigger_pin && !trig_r;
            frt_pkg::EDGE_FALL: edge_hit = !i_capture_trigger_pin && trig_r;
            frt_pkg::EDGE_BOTH: edge_hit = i_capture_trigger_pin != trig_r;
            default: edge_hit = 1'b0;
        endcase
        cap_pend_nxt = edge_hit;
        cap_nxt = cap_pend_r ? count_r : cap_r;
    end

    // ***********************************
    // Read buffer, read data and pin
    // ***********************************
    always_comb
    begin
        buf_nxt = buf_r;
        case (buf_r)
            frt_pkg::FRT_BUF_TRACK:
                if (i_bus.rd && i_bus.addr == frt_pkg::ADDR_CNT_LO)
                    buf_nxt = frt_pkg::FRT_BUF_HELD;
            frt_pkg::FRT_BUF_HELD:
                if (i_bus.rd && i_bus.addr == frt_pkg::ADDR_CNT_HI)
                    buf_nxt = frt_pkg::FRT_BUF_TRACK;
            default: buf_nxt = frt_pkg::FRT_BUF_TRACK;
        endcase
        rbuf_nxt = (buf_r == frt_pkg::FRT_BUF_TRACK) ? count_r : rbuf_r;
        rdata_nxt = 8'h00;
        if (i_bus.addr == frt_pkg::ADDR_TMODE)
            rdata_nxt = tmode_r;
        else if (i_bus.addr == frt_pkg::ADDR_PORT5_DIR)
            rdata_nxt = pdir_r;
        else if (i_bus.addr == frt_pkg::ADDR_CMP_LO)
            rdata_nxt = cmp_r[7:0];
        else if (i_bus.addr == frt_pkg::ADDR_CMP_HI)
            rdata_nxt = cmp_r[15:8];
        else if (i_bus.addr == frt_pkg::ADDR_CNT_LO)
            rdata_nxt = (buf_r == frt_pkg::FRT_BUF_TRACK) ? count_r[7:0] : rbuf_r[7:0];
        else if (i_bus.addr == frt_pkg::ADDR_CNT_HI)
            rdata_nxt = rbuf_r[15:8];
        else if (i_bus.addr == frt_pkg::ADDR_CAP_LO)
            rdata_nxt = cap_r[7:0];
        else if (i_bus.addr == frt_pkg::ADDR_CAP_HI)
            rdata_nxt = cap_r[15:8];
        if (!i_bus.rd)
            rdata_nxt = 8'h00;
        // Pin: timer data when enabled, else port latch
        pin_nxt = tmode_nxt[frt_pkg::BIT_OE] ? tmode_nxt[frt_pkg::BIT_OUT_DATA]
                                             : i_output_port_pin;
        oen_nxt = pdir_nxt[frt_pkg::BIT_PIN_DIR];
    end

    // ***********************************
    // Registers
    // ***********************************
    // Counter, compare, mode, direction and request
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            count_r <= frt_pkg::RST_CNT;
            cmp_r <= frt_pkg::RST_CMP;
            tmode_r <= frt_pkg::RST_TMODE;
            pdir_r <= frt_pkg::RST_PORT5_DIR;
            irq_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            cmp_r <= cmp_nxt;
            tmode_r <= tmode_nxt;
            pdir_r <= pdir_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Trigger edge and capture
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            trig_r <= 1'b0;
            cap_pend_r <= 1'b0;
            cap_r <= frt_pkg::RST_CNT;
        end
        else
        begin
            trig_r <= trig_nxt;
            cap_pend_r <= cap_pend_nxt;
            cap_r <= cap_nxt;
        end
    end

    // Read buffer, read data and pin
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rbuf_r <= frt_pkg::RST_CNT;
            buf_r <= frt_pkg::FRT_BUF_TRACK;
            o_rdata <= 8'h00;
            pin_r <= 1'b0;
            oen_r <= 1'b1;
        end
        else
        begin
            rbuf_r <= rbuf_nxt;
            buf_r <= buf_nxt;
            o_rdata <= rdata_nxt;
            pin_r <= pin_nxt;
            oen_r <= oen_nxt;
        end
    end
    assign o_match_interrupt_request = irq_r;
    assign o_timer_output_pin = pin_r;
    assign o_timer_output_pin_oen = oen_r;

    // ***********************************
    // Assertions
    // ***********************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // Cycles the request has been high, for its length checks
    logic [5:0] irq_len_r;
    logic [5:0] irq_len_nxt;
    always_comb
    begin
        irq_len_nxt = 6'h00;
        if (irq_r && irq_len_r != 6'h3f)
            irq_len_nxt = irq_len_r + 6'h01;
        else if (irq_r)
            irq_len_nxt = irq_len_r;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            irq_len_r <= 6'h00;
        else
            irq_len_r <= irq_len_nxt;
    end

    a_count_step: assert property (tick |=> count_r == $past(count_r) + 16'h0001)
        else $error("counter did not step on tick");
    a_count_hold: assert property (!tick |=> $stable(count_r))
        else $error("counter moved without tick");
    a_match_irq: assert property (match |=> irq_r)
        else $error("match gave no request");
    a_irq_cause: assert property ($rose(irq_r) |-> $past(match))
        else $error("request without match");
    a_irq_hold: assert property (irq_r && half && !tick |=> irq_r)
        else $error("request dropped before half period");
    a_irq_drop: assert property (irq_r && !half && !match |=> !irq_r)
        else $error("request held past half period");
    a_irq_len: assert property (irq_r |-> irq_len_r < 6'(frt_pkg::DIV_SLOW / 2))
        else $error("request longer than half slow period");
    a_irq_min: assert property ($fell(irq_r) |-> $past(irq_len_r) != 6'h00)
        else $error("request shorter than two cycles");
    a_invert_out: assert property (match && tmode_r[3] && !wr_tmode
        |=> tmode_r[7] != $past(tmode_r[7]))
        else $error("output data not inverted");
    a_noinv_hold: assert property (match && !tmode_r[3] && !wr_tmode |=> $stable(tmode_r[7]))
        else $error("output data changed without inversion");
    a_out_data_ro: assert property (wr_tmode && !match
        && !(i_bus.wdata[0] && !tmode_r[0]) |=> $stable(tmode_r[7]))
        else $error("write changed output data bit");
    a_ovf_set: assert property (tick && count_r == 16'hffff |=> tmode_r[6])
        else $error("overflow flag not set");
    a_ovf_sticky: assert property (tmode_r[6] && !wr_tmode |=> tmode_r[6])
        else $error("overflow flag lost");
    a_ovf_clear: assert property (wr_tmode && !i_bus.wdata[6]
        && !(tick && count_r == 16'hffff) |=> !tmode_r[6])
        else $error("overflow flag not cleared by write of 0");
    a_cmp_write_lo: assert property (i_bus.wr && i_bus.addr == frt_pkg::ADDR_CMP_LO
        |=> cmp_r[7:0] == $past(i_bus.wdata))
        else $error("compare low byte not written");
    a_cmp_write_hi: assert property (i_bus.wr && i_bus.addr == frt_pkg::ADDR_CMP_HI
        |=> cmp_r[15:8] == $past(i_bus.wdata))
        else $error("compare high byte not written");
    a_capture_time: assert property (edge_hit |-> ##2 cap_r == $past(count_r))
        else $error("capture value wrong");
    a_cap_hold: assert property (!cap_pend_r |=> $stable(cap_r))
        else $error("capture register moved without edge");
    a_edge_off: assert property (tmode_r[5:4] == frt_pkg::EDGE_OFF |-> !edge_hit)
        else $error("edge seen with capture disabled");
    a_buf_frozen: assert property (buf_r == frt_pkg::FRT_BUF_HELD
        && !(i_bus.rd && i_bus.addr == frt_pkg::ADDR_CNT_HI) |=> $stable(rbuf_r))
        else $error("frozen buffer moved");
    a_buf_freeze: assert property (buf_r == frt_pkg::FRT_BUF_TRACK
        && i_bus.rd && i_bus.addr == frt_pkg::ADDR_CNT_LO
        |=> buf_r == frt_pkg::FRT_BUF_HELD && rbuf_r == $past(count_r))
        else $error("buffer did not freeze on low read");
    a_buf_release: assert property (buf_r == frt_pkg::FRT_BUF_HELD
        && i_bus.rd && i_bus.addr == frt_pkg::ADDR_CNT_HI
        |=> buf_r == frt_pkg::FRT_BUF_TRACK)
        else $error("buffer not released on high read");
    a_oe_start_low: assert property (wr_tmode && i_bus.wdata[0] && !tmode_r[0] && !tick
        |=> !tmode_r[7])
        else $error("output not low at enable");
    a_pin_port: assert property (!tmode_nxt[0] |=> pin_r == $past(i_output_port_pin))
        else $error("pin not following port latch");
    c_match: cover property (match);
    c_capture: cover property (edge_hit ##2 1'b1);
    c_overflow: cover property ($rose(tmode_r[6]));
    c_frozen_read: cover property (buf_r == frt_pkg::FRT_BUF_HELD ##1 buf_r == frt_pkg::FRT_BUF_TRACK);
    c_irq_end: cover property ($fell(irq_r));
endmodule

// file: verification/frt_far_side.sv
/*
 Far side of the timer pins: capture trigger source and output load.
 Assumes the bench commands trigger levels; the load has no pull resistor.
*/
`timescale 1ns/100ps
module frt_far_side
(
    input wire logic i_clk_sys,
    input wire logic i_level,
    input wire logic i_slow,
    input wire logic i_pin,
    input wire logic i_pin_oen,
    output logic o_trigger,
    output logic o_load
);
    logic last_r = 1'b0;
    logic dly_r = 1'b0;
    always_ff @(posedge i_clk_sys)
    begin
        dly_r <= i_level;
        if (!i_pin_oen)
        begin
            last_r <= i_pin;
        end
    end
    // Slow source lags one clock
    assign o_trigger = i_slow ? dly_r : i_level;
    // Undriven wire shows the inverse of its last level
    assign o_load = i_pin_oen ? ~last_r : i_pin;
endmodule

// file: verification/test_free_running_timer_compare_capture.sv
/*
 Self-checking bench for the timer: bus tasks, scenarios, verdict.
 Assumes frt_pkg, frt_timer and frt_far_side are compiled first.
*/
`timescale 1ns/100ps
module test_free_running_timer_compare_capture;
    logic i_clk_sys, i_resetn, lvl, slow, port_pin, trig, load, req, pin, oen;
    frt_pkg::frt_bus_t bus;
    logic [7:0] rdata, b;
    logic [15:0] c, c2, p, q;
    int n_fail = 0, n_compared = 0, cyc = 0;
    frt_timer dut_u
    (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_bus(bus),
        .i_capture_trigger_pin(trig),
        .i_output_port_pin(port_pin),
        .o_rdata(rdata),
        .o_match_interrupt_request(req),
        .o_timer_output_pin(pin),
        .o_timer_output_pin_oen(oen)
    );
    frt_far_side far_u
    (
        .i_clk_sys(i_clk_sys),
        .i_level(lvl),
        .i_slow(slow),
        .i_pin(pin),
        .i_pin_oen(oen),
        .o_trigger(trig),
        .o_load(load)
    );
    // ***********************************
    // Tasks
    // ***********************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk_sys);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rpair(input logic [15:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 16'h0001, v[15:8]);
    endtask
    task automatic arm(input logic [7:0] mode);
        int k;
        k = 0;
        wr(frt_pkg::ADDR_TMODE, 8'h01);
        rpair(frt_pkg::ADDR_CNT_LO, c);
        c = c + 16'h0040;
        wr(frt_pkg::ADDR_CMP_HI, c[15:8]);
        wr(frt_pkg::ADDR_CMP_LO, c[7:0]);
        wr(frt_pkg::ADDR_TMODE, mode);
        while (req !== 1'b1 && k < 400)
        begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        chk(16'(k < 400), 16'h0001);
        repeat (3) @(posedge i_clk_sys);
    endtask
    task automatic report_and_stop;
        $display("compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ***********************************
    // Clock and timeout
    // ***********************************
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    // ***********************************
    // Scenarios
    // ***********************************
    initial
    begin
        bus = '0;
        lvl = 1'b0;
        slow = 1'b0;
        port_pin = 1'b1;
        i_resetn = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(frt_pkg::ADDR_TMODE, b); chk(b, 8'h00);
        rd(frt_pkg::ADDR_CMP_LO, b); chk(b, 8'hff);
        rd(frt_pkg::ADDR_CMP_HI, b); chk(b, 8'hff);
        rd(frt_pkg::ADDR_PORT5_DIR, b); chk(b, 8'hff);
        rd(frt_pkg::ADDR_CNT_LO, b);
        repeat (2100) @(posedge i_clk_sys);
        rd(frt_pkg::ADDR_CNT_LO, b);
        rd(frt_pkg::ADDR_CNT_HI, b); chk(b, 8'h00);
        rpair(frt_pkg::ADDR_CNT_LO, c); chk(c[15:8], 8'h02);
        wr(frt_pkg::ADDR_TMODE, 8'hc0);
        rd(frt_pkg::ADDR_TMODE, b); chk(b, 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            wr(frt_pkg::ADDR_TMODE, 8'(i * 2));
            rpair(frt_pkg::ADDR_CNT_LO, c);
            repeat (640) @(posedge i_clk_sys);
            rpair(frt_pkg::ADDR_CNT_LO, c2);
            p = 16'(644 / (i == 0 ? frt_pkg::DIV_FAST : frt_pkg::DIV_SLOW));
            chk(16'((c2 - c) + 16'h0001 - p <= 16'h0002), 16'h0001);
        end
        wr(frt_pkg::ADDR_PORT5_DIR, 8'hfd);
        wr(frt_pkg::ADDR_TMODE, 8'h01);
        chk({pin, oen, load}, 16'h0000);
        arm(8'h09);
        chk({pin, load}, 16'h0003);
        rd(frt_pkg::ADDR_TMODE, b); chk(b, 8'h89);
        rpair(frt_pkg::ADDR_CNT_LO, c2); chk(16'(c2 > c), 16'h0001);
        arm(8'h01);
        chk(pin, 16'h0001);
        wr(frt_pkg::ADDR_TMODE, 8'h00);
        port_pin <= 1'b0;
        #21 chk(pin, 16'h0000);
        for (int m = 0; m < 4; m++)
        begin
            for (int e = 0; e < 2; e++)
            begin
                slow <= (m > 1);
                rpair(frt_pkg::ADDR_CAP_LO, p);
                wr(frt_pkg::ADDR_TMODE, 8'(m << 4));
                repeat (20) @(posedge i_clk_sys);
                lvl <= ~lvl;
                repeat (4) @(posedge i_clk_sys);
                wr(frt_pkg::ADDR_TMODE, 8'h00);
                rpair(frt_pkg::ADDR_CAP_LO, q);
                chk(16'(q !== p), 16'((m >> e) & 1));
            end
        end
        report_and_stop();
    end
endmodule
